// [verilog/apsp_map.svh]
`ifndef APSP_MAP_SVH
`define APSP_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define APSP_OFS_STEER0 8'h00
`define APSP_OFS_STEER1 8'h04
`define APSP_OFS_PORT 8'h08
`define APSP_OFS_LAT 8'h0c
`define APSP_OFS_DIR 8'h10
`define APSP_OFS_ANSEL 8'h14
`define APSP_OFS_WPU 8'h18
`define APSP_OFS_OPT 8'h1c
`define APSP_OFS_BSET 8'h20
`define APSP_OFS_BCLR 8'h24

// ----------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------
`define APSP_RST_STEER 8'h00
`define APSP_RST_DIR 8'hff
`define APSP_RST_ANSEL 8'h1f
`define APSP_RST_WPU 8'h20
`define APSP_RST_OPT 8'h80
`define APSP_RST_LAT 8'h00
`define APSP_MSK_S1 8'h01
`define APSP_MSK_LAT 8'hdf
`define APSP_MSK_ANSEL 8'h1f
`define APSP_MSK_WPU 8'h20
`define APSP_MSK_OPT 8'h80
`define APSP_DIR_FORCE 8'h20

// ----------------------------------------
// selection bits and pin positions
// ----------------------------------------
`define APSP_SEL_RX 3'h7
`define APSP_SEL_SDO 3'h6
`define APSP_SEL_SS 3'h5
`define APSP_SEL_P2B 3'h4
`define APSP_SEL_CC2 3'h3
`define APSP_SEL_P1D 3'h2
`define APSP_SEL_P1C 3'h1
`define APSP_SEL_CC1 3'h0
`define APSP_SEL_TX 3'h0
`define APSP_OPT_GPD 3'h7
`define APSP_P0 3'h0
`define APSP_P1 3'h1
`define APSP_P2 3'h2
`define APSP_P3 3'h3
`define APSP_P5 3'h5
`define APSP_P6 3'h6
`define APSP_P7 3'h7

`endif

// [verilog/apsp_pkg.sv]
package apsp_pkg;

	// peripheral override of one pin: owns it, drives it, level
	typedef struct packed {
		logic en;
		logic oe;
		logic dat;
	} apsp_ovr_t;

	// one-hot register select
	typedef enum logic [10:0] {
		APSP_R_NONE = 11'h001,
		APSP_R_STEER0 = 11'h002,
		APSP_R_STEER1 = 11'h004,
		APSP_R_PORT = 11'h008,
		APSP_R_LAT = 11'h010,
		APSP_R_DIR = 11'h020,
		APSP_R_ANSEL = 11'h040,
		APSP_R_WPU = 11'h080,
		APSP_R_OPT = 11'h100,
		APSP_R_BSET = 11'h200,
		APSP_R_BCLR = 11'h400
	} apsp_reg_t;

endpackage

// [verilog/apsp_top.sv]
`timescale 1ns/100ps
`include "apsp_map.svh"
// Overview of operation
// - receive input from selected port B pin
// - spi data-out on port B2 or A6
// - slave select from port B5 or A5
// - pwm2 B output on B7 or A6
// - capcmp2 on B6 or A7
// - pwm1 D output on B7 or A6
// - pwm1 C output on B6 or A7
// - capcmp1 on B3 or B0
// - transmit/clock on B2 or B5
// - steering never touches direction; overrides follow selection
// - unselected pin keeps plain port behaviour
// - direction one disables driver, zero drives latch
// - port A bit5 input only, reads one
// - port read returns pins, write hits latch
// - bit-set/clear writes sample pins, modify, store
// - direction controls driver even for analog pins
// - analog-selected pins read digital zero
// - bit5 pull-up from its bit, off if output
// - pull-ups disabled after reset by global bit
// - analog select leaves digital output driving
// - analog select bits reset to analog
// - pull-up only while global disable cleared

module apsp_top #(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pa_pin_i,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe_n,
	output logic pa5_pullup,
	input wire logic [7:0] pb_pin_i,
	output apsp_pkg::apsp_ovr_t [7:0] pb_ovr,
	input wire apsp_pkg::apsp_ovr_t serial_transmit_clock,
	input wire apsp_pkg::apsp_ovr_t spi1_data_out,
	input wire apsp_pkg::apsp_ovr_t pwm2_channel_b,
	input wire apsp_pkg::apsp_ovr_t capcmp2_pwm2_channel_a,
	input wire apsp_pkg::apsp_ovr_t pwm1_channel_d,
	input wire apsp_pkg::apsp_ovr_t pwm1_channel_c,
	input wire apsp_pkg::apsp_ovr_t capcmp1_pwm1_channel_a,
	output logic serial_receive_data,
	output logic spi1_slave_select,
	output logic capcmp1_in,
	output logic capcmp2_in
);

	// ----------------------------------------
	// functions
	// ----------------------------------------

	// address to one-hot register select
	function automatic apsp_pkg::apsp_reg_t dec(input logic [AW-1:0] a);
		case (a[7:0])
			`APSP_OFS_STEER0: dec = apsp_pkg::APSP_R_STEER0;
			`APSP_OFS_STEER1: dec = apsp_pkg::APSP_R_STEER1;
			`APSP_OFS_PORT: dec = apsp_pkg::APSP_R_PORT;
			`APSP_OFS_LAT: dec = apsp_pkg::APSP_R_LAT;
			`APSP_OFS_DIR: dec = apsp_pkg::APSP_R_DIR;
			`APSP_OFS_ANSEL: dec = apsp_pkg::APSP_R_ANSEL;
			`APSP_OFS_WPU: dec = apsp_pkg::APSP_R_WPU;
			`APSP_OFS_OPT: dec = apsp_pkg::APSP_R_OPT;
			`APSP_OFS_BSET: dec = apsp_pkg::APSP_R_BSET;
			`APSP_OFS_BCLR: dec = apsp_pkg::APSP_R_BCLR;
			default: dec = apsp_pkg::APSP_R_NONE;
		endcase
	endfunction

	// first override wins if it owns the pin
	function automatic apsp_pkg::apsp_ovr_t pick(
		input apsp_pkg::apsp_ovr_t hi,
		input apsp_pkg::apsp_ovr_t lo
	);
		pick = hi.en ? hi : lo;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] pa_s1_ff; // first sync stage, read only by second
	logic [7:0] pa_s2_ff;
	logic [7:0] pb_s1_ff;
	logic [7:0] pb_s2_ff;
	logic [7:0] steer0_ff; // pin_steering_select_0
	logic [7:0] steer1_ff; // pin_steering_select_1
	logic [7:0] lat_ff; // port_a_output_latch
	logic [7:0] dir_ff; // port_a_direction
	logic [7:0] ansel_ff; // port_a_analog_select
	logic [7:0] wpu_ff; // port_a_pullup_enable
	logic [7:0] opt_ff; // global_pullup_disable in bit 7
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] pa_out_ff;
	logic [7:0] pa_oe_n_ff;
	logic pullup_ff;
	apsp_pkg::apsp_ovr_t [7:0] pb_ovr_ff;
	logic rx_ff;
	logic ss_ff;
	logic cc1_ff;
	logic cc2_ff;

	// ----------------------------------------
	// combinational helpers
	// ----------------------------------------
	apsp_pkg::apsp_reg_t sel; // decoded target of this transfer
	logic acc; // access phase completing this edge
	logic wr_en; // write takes effect this edge
	logic [7:0] wd; // low byte of write data
	logic [7:0] pa_rd; // digital view of port A pins
	logic [7:0] rd_byte; // read mux
	logic [7:0] nxt_pa_out;
	logic [7:0] nxt_pa_oe_n;
	apsp_pkg::apsp_ovr_t [7:0] nxt_pb_ovr;
	apsp_pkg::apsp_ovr_t ov6;
	apsp_pkg::apsp_ovr_t ov7;
	apsp_pkg::apsp_ovr_t none_ovr;

	assign sel = dec(paddr);
	assign acc = ce & psel & penable & pready_ff;
	// lane 0 strobe gates the byte; upper lanes are unused
	assign wr_en = acc & pwrite & pstrb[0];
	assign wd = pwdata[7:0];
	assign none_ovr = '0;
	// analog pins read zero; their input buffer is off
	assign pa_rd = pa_s2_ff & ~ansel_ff;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------

	// pins are asynchronous: two stages before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_s1_ff <= 8'h00;
			pa_s2_ff <= 8'h00;
			pb_s1_ff <= 8'h00;
			pb_s2_ff <= 8'h00;
		end else if (ce) begin
			pa_s1_ff <= pa_pin_i;
			pa_s2_ff <= pa_s1_ff;
			pb_s1_ff <= pb_pin_i;
			pb_s2_ff <= pb_s1_ff;
		end
	end

	// ----------------------------------------
	// steering registers
	// ----------------------------------------

	// selection bits only; direction is left alone here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steer0_ff <= `APSP_RST_STEER;
			steer1_ff <= `APSP_RST_STEER;
		end else if (wr_en) begin
			if (sel == apsp_pkg::APSP_R_STEER0) begin
				steer0_ff <= wd;
			end
			if (sel == apsp_pkg::APSP_R_STEER1) begin
				steer1_ff <= wd & `APSP_MSK_S1; // upper bits read zero
			end
		end
	end

	// ----------------------------------------
	// port A latch
	// ----------------------------------------

	// bit-set and bit-clear sample pins, modify, then store; with analog
	// pins read as zero a bit-set can clear their latch bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_ff <= `APSP_RST_LAT;
		end else if (wr_en) begin
			case (sel)
				apsp_pkg::APSP_R_PORT, apsp_pkg::APSP_R_LAT: begin
					lat_ff <= wd & `APSP_MSK_LAT;
				end
				apsp_pkg::APSP_R_BSET: begin
					lat_ff <= (pa_rd | wd) & `APSP_MSK_LAT;
				end
				apsp_pkg::APSP_R_BCLR: begin
					lat_ff <= (pa_rd & ~wd) & `APSP_MSK_LAT;
				end
				default: lat_ff <= lat_ff;
			endcase
		end
	end

	// ----------------------------------------
	// direction, analog, pull-up, option
	// ----------------------------------------

	// bit 5 direction forced to input on every write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_ff <= `APSP_RST_DIR;
		end else if (wr_en && sel == apsp_pkg::APSP_R_DIR) begin
			dir_ff <= wd | `APSP_DIR_FORCE;
		end
	end

	// analog select comes up analog
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ansel_ff <= `APSP_RST_ANSEL;
		end else if (wr_en && sel == apsp_pkg::APSP_R_ANSEL) begin
			ansel_ff <= wd & `APSP_MSK_ANSEL;
		end
	end

	// pull-up enable and global disable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wpu_ff <= `APSP_RST_WPU;
			opt_ff <= `APSP_RST_OPT;
		end else if (wr_en) begin
			if (sel == apsp_pkg::APSP_R_WPU) begin
				wpu_ff <= wd & `APSP_MSK_WPU;
			end
			if (sel == apsp_pkg::APSP_R_OPT) begin
				opt_ff <= wd & `APSP_MSK_OPT;
			end
		end
	end

	// ----------------------------------------
	// apb read path
	// ----------------------------------------

	// read byte for the decoded register
	always_comb begin
		case (sel)
			apsp_pkg::APSP_R_STEER0: rd_byte = steer0_ff;
			apsp_pkg::APSP_R_STEER1: rd_byte = steer1_ff;
			apsp_pkg::APSP_R_PORT: rd_byte = pa_rd;
			apsp_pkg::APSP_R_LAT: rd_byte = lat_ff;
			apsp_pkg::APSP_R_DIR: rd_byte = dir_ff | `APSP_DIR_FORCE;
			apsp_pkg::APSP_R_ANSEL: rd_byte = ansel_ff;
			apsp_pkg::APSP_R_WPU: rd_byte = wpu_ff;
			apsp_pkg::APSP_R_OPT: rd_byte = opt_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	// answer registered in setup, so access never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff <= psel & ~penable;
			pslverr_ff <= psel & ~penable & (sel == apsp_pkg::APSP_R_NONE);
			if (psel && !penable && !pwrite) begin
				prdata_ff <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ----------------------------------------
	// output routing
	// ----------------------------------------

	// plain port first, then peripheral overrides on selected pins
	always_comb begin
		nxt_pa_out = lat_ff;
		nxt_pa_oe_n = dir_ff;
		nxt_pb_ovr = '0;
		// pin A6: data-out over pwm1 D over pwm2 B
		ov6 = pick(steer0_ff[`APSP_SEL_SDO] ? spi1_data_out : none_ovr,
			pick(steer0_ff[`APSP_SEL_P1D] ? pwm1_channel_d : none_ovr,
			steer0_ff[`APSP_SEL_P2B] ? pwm2_channel_b : none_ovr));
		// pin A7: pwm1 C over capcmp2
		ov7 = pick(steer0_ff[`APSP_SEL_P1C] ? pwm1_channel_c : none_ovr,
			steer0_ff[`APSP_SEL_CC2] ? capcmp2_pwm2_channel_a : none_ovr);
		if (ov6.en) begin
			nxt_pa_out[`APSP_P6] = ov6.dat;
			nxt_pa_oe_n[`APSP_P6] = ~ov6.oe;
		end
		if (ov7.en) begin
			nxt_pa_out[`APSP_P7] = ov7.dat;
			nxt_pa_oe_n[`APSP_P7] = ~ov7.oe;
		end
		// input-only pin never drives
		nxt_pa_out[`APSP_P5] = 1'b0;
		nxt_pa_oe_n[`APSP_P5] = 1'b1;
		// port B side: overrides handed to the port B logic
		nxt_pb_ovr[`APSP_P0] = steer0_ff[`APSP_SEL_CC1] ? capcmp1_pwm1_channel_a : none_ovr;
		nxt_pb_ovr[`APSP_P3] = steer0_ff[`APSP_SEL_CC1] ? none_ovr : capcmp1_pwm1_channel_a;
		nxt_pb_ovr[`APSP_P2] = pick(steer1_ff[`APSP_SEL_TX] ? none_ovr : serial_transmit_clock,
			steer0_ff[`APSP_SEL_SDO] ? none_ovr : spi1_data_out);
		nxt_pb_ovr[`APSP_P5] = steer1_ff[`APSP_SEL_TX] ? serial_transmit_clock : none_ovr;
		nxt_pb_ovr[`APSP_P6] = pick(steer0_ff[`APSP_SEL_P1C] ? none_ovr : pwm1_channel_c,
			steer0_ff[`APSP_SEL_CC2] ? none_ovr : capcmp2_pwm2_channel_a);
		nxt_pb_ovr[`APSP_P7] = pick(steer0_ff[`APSP_SEL_P1D] ? none_ovr : pwm1_channel_d,
			steer0_ff[`APSP_SEL_P2B] ? none_ovr : pwm2_channel_b);
	end

	// registered pin drive; one cycle behind the registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_out_ff <= 8'h00;
			pa_oe_n_ff <= 8'hff;
			pb_ovr_ff <= '0;
		end else if (ce) begin
			pa_out_ff <= nxt_pa_out;
			pa_oe_n_ff <= nxt_pa_oe_n;
			pb_ovr_ff <= nxt_pb_ovr;
		end
	end

	// pull-up needs enable, global enable and input direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_ff <= 1'b0;
		end else if (ce) begin
			pullup_ff <= wpu_ff[`APSP_P5] & ~opt_ff[`APSP_OPT_GPD] & dir_ff[`APSP_P5];
		end
	end

	// ----------------------------------------
	// steered peripheral inputs
	// ----------------------------------------

	// only the selected pin feeds each input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ff <= 1'b1;
			ss_ff <= 1'b1;
			cc1_ff <= 1'b0;
			cc2_ff <= 1'b0;
		end else if (ce) begin
			rx_ff <= steer0_ff[`APSP_SEL_RX] ? pb_s2_ff[`APSP_P2] : pb_s2_ff[`APSP_P1];
			ss_ff <= steer0_ff[`APSP_SEL_SS] ? pa_rd[`APSP_P5] : pb_s2_ff[`APSP_P5];
			cc1_ff <= steer0_ff[`APSP_SEL_CC1] ? pb_s2_ff[`APSP_P0] : pb_s2_ff[`APSP_P3];
			cc2_ff <= steer0_ff[`APSP_SEL_CC2] ? pa_rd[`APSP_P7] : pb_s2_ff[`APSP_P6];
		end
	end

	// ----------------------------------------
	// output ports
	// ----------------------------------------
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign pa_out = pa_out_ff;
	assign pa_oe_n = pa_oe_n_ff;
	assign pa5_pullup = pullup_ff;
	assign pb_ovr = pb_ovr_ff;
	assign serial_receive_data = rx_ff;
	assign spi1_slave_select = ss_ff;
	assign capcmp1_in = cc1_ff;
	assign capcmp2_in = cc2_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// reset values still stand at the first edge after release
	a_rx_route: assert property ($past(presetn) && $past(ce) |-> rx_ff ==
		($past(steer0_ff[`APSP_SEL_RX]) ? $past(pb_s2_ff[`APSP_P2]) : $past(pb_s2_ff[`APSP_P1])))
		else $error("receive input from wrong pin");

	a_sdo_pa6: assert property (ce && steer0_ff[`APSP_SEL_SDO] && spi1_data_out.en
		|=> pa_out_ff[`APSP_P6] == $past(spi1_data_out.dat) && pa_oe_n_ff[`APSP_P6] == !$past(spi1_data_out.oe))
		else $error("data-out not on port A pin 6");

	a_ss_route: assert property (presetn && ce && !steer0_ff[`APSP_SEL_SS] |=> ss_ff == $past(pb_s2_ff[`APSP_P5]))
		else $error("slave select from wrong pin");

	a_pa5_input: assert property (pa_oe_n_ff[`APSP_P5] && !pa_out_ff[`APSP_P5])
		else $error("input-only pin driven");

	a_drive_dir: assert property (ce ##1 ce |-> pa_oe_n_ff[`APSP_P0] == $past(dir_ff[`APSP_P0])
		&& pa_out_ff[`APSP_P0] == $past(lat_ff[`APSP_P0])) else $error("pin 0 drive mismatch");

	a_ansel_read: assert property (acc && !pwrite && sel == apsp_pkg::APSP_R_PORT
		|-> (prdata_ff[7:0] & ansel_ff) == 8'h00) else $error("analog pin read nonzero");

	a_pullup_gate: assert property ($past(ce) && pullup_ff |->
		!$past(opt_ff[`APSP_OPT_GPD]) && $past(wpu_ff[`APSP_P5])) else $error("pull-up on while disabled");

	a_dir_kept: assert property (wr_en && (sel == apsp_pkg::APSP_R_STEER0 ||
		sel == apsp_pkg::APSP_R_STEER1) |=> $stable(dir_ff)) else $error("steering changed direction");

	a_unsel_pa6: assert property (ce && steer0_ff[7:0] == 8'h00 |=>
		pa_out_ff[`APSP_P6] == $past(lat_ff[`APSP_P6]) && pa_oe_n_ff[`APSP_P6] == $past(dir_ff[`APSP_P6]))
		else $error("unselected pin disturbed");

	a_rmw_set: assert property (wr_en && sel == apsp_pkg::APSP_R_BSET |=>
		lat_ff == $past((pa_rd | wd) & `APSP_MSK_LAT)) else $error("bit-set latch wrong");

	a_tx_pb5: assert property (ce && steer1_ff[`APSP_SEL_TX] |=>
		pb_ovr_ff[`APSP_P5] == $past(serial_transmit_clock)) else $error("transmit not on port B pin 5");

	c_steer_write: cover property (wr_en && sel == apsp_pkg::APSP_R_STEER0 ##2 pa_oe_n_ff[`APSP_P6] == 1'b0);
	c_port_read: cover property (acc && !pwrite && sel == apsp_pkg::APSP_R_PORT);
	c_pullup_on: cover property (pullup_ff);
	c_bad_addr: cover property (pslverr_ff && pready_ff);

endmodule

// [test/apsp_far.sv]
`timescale 1ns/100ps
// ----------------------------------------
// far side: port A pads with outside drivers
// ----------------------------------------
module apsp_far (
	input wire logic pclk,
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe_n,
	input wire logic pa5_pullup,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pa_pin_i
);
	logic wander_ff = 1'b0; // stands in for a floating level
	// toggles so a released pad never passes for its last value
	always @(posedge pclk) begin
		wander_ff <= ~wander_ff;
	end
	// pad level: own driver first, then outside driver, then pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pa_oe_n[i]) begin
				pa_pin_i[i] = pa_out[i];
			end else if (ext_en[i]) begin
				pa_pin_i[i] = ext_val[i];
			end else if (i == 5 && pa5_pullup) begin
				pa_pin_i[i] = 1'b1;
			end else begin
				pa_pin_i[i] = wander_ff ^ i[0];
			end
		end
	end
endmodule

// [test/alt_pin_steering_port_a_bench.sv]
`timescale 1ns/100ps
`include "apsp_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module alt_pin_steering_port_a_bench;
	// ----------------------------------------
	// signals and behavioural register image
	// ----------------------------------------
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, pa5_pullup, rx_o, ss_o, cc1_o, cc2_o;
	logic ce_i; // clock enable, low freezes the block
	logic [7:0] paddr, pa_pin_i, pa_out, pa_oe_n, pb_pin_i, ext_en, ext_val;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	apsp_pkg::apsp_ovr_t [7:0] pb_ovr;
	apsp_pkg::apsp_ovr_t per [7]; // tx, sdo, p2b, cc2, p1d, p1c, cc1
	logic [7:0] m_s0, m_s1, m_lat, m_dir, m_an, m_wpu, m_opt;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int rs;
	always #2 pclk = ~pclk; // 250 MHz
	apsp_top #(.AW(8)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pa_pin_i(pa_pin_i), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa5_pullup(pa5_pullup),
		.pb_pin_i(pb_pin_i), .pb_ovr(pb_ovr), .serial_transmit_clock(per[0]), .spi1_data_out(per[1]),
		.pwm2_channel_b(per[2]), .capcmp2_pwm2_channel_a(per[3]), .pwm1_channel_d(per[4]),
		.pwm1_channel_c(per[5]), .capcmp1_pwm1_channel_a(per[6]), .serial_receive_data(rx_o),
		.spi1_slave_select(ss_o), .capcmp1_in(cc1_o), .capcmp2_in(cc2_o));
	apsp_far i_far (.pclk(pclk), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa5_pullup(pa5_pullup),
		.ext_en(ext_en), .ext_val(ext_val), .pa_pin_i(pa_pin_i));
	// hang guard: generous against roughly 3700 cycles of tests
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// one transfer; waits for pready whatever the latency
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic er;
		apb(1'b0, a, 8'h00, 4'h0, d, er);
		`CHK(d, e)
		`CHK(er, a > `APSP_OFS_BCLR)
	endtask
	// write and mirror it in the image; strobe bit 0 low means ignored
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st);
		logic [31:0] r;
		logic er;
		logic [7:0] pins;
		repeat (4) @(posedge pclk); // synced pins must settle before a set/clear samples them
		pins = pin_rd();
		apb(1'b1, a, d, st, r, er);
		`CHK(er, a > `APSP_OFS_BCLR)
		if (st[0]) begin
			case (a)
				`APSP_OFS_STEER0: m_s0 = d;
				`APSP_OFS_STEER1: m_s1 = d & `APSP_MSK_S1;
				`APSP_OFS_PORT, `APSP_OFS_LAT: m_lat = d & `APSP_MSK_LAT;
				`APSP_OFS_DIR: m_dir = d | `APSP_DIR_FORCE;
				`APSP_OFS_ANSEL: m_an = d & `APSP_MSK_ANSEL;
				`APSP_OFS_WPU: m_wpu = d & `APSP_MSK_WPU;
				`APSP_OFS_OPT: m_opt = d & `APSP_MSK_OPT;
				`APSP_OFS_BSET: m_lat = (pins | d) & `APSP_MSK_LAT;
				`APSP_OFS_BCLR: m_lat = pins & ~d & `APSP_MSK_LAT;
				default: ;
			endcase
		end
	endtask
	// ----------------------------------------
	// expectation model
	// ----------------------------------------
	// first candidate wins if selected and enabled; else a selected second passes whole
	function automatic apsp_pkg::apsp_ovr_t pick(input logic s1, input apsp_pkg::apsp_ovr_t a,
		input logic s2, input apsp_pkg::apsp_ovr_t b);
		if (s1 && a.en) return a;
		if (s2) return b;
		return '0;
	endfunction
	// port A pad controls: {oe_n, out}
	function automatic logic [15:0] a_side();
		logic [7:0] oe_n, o;
		apsp_pkg::apsp_ovr_t a6, a7;
		a6 = pick(m_s0[6], per[1], 1'b1, pick(m_s0[2], per[4], m_s0[4], per[2]));
		a7 = pick(m_s0[1], per[5], m_s0[3], per[3]);
		oe_n = m_dir | `APSP_DIR_FORCE;
		o = m_lat;
		if (a6.en) begin
			oe_n[6] = ~a6.oe;
			o[6] = a6.dat;
		end
		if (a7.en) begin
			oe_n[7] = ~a7.oe;
			o[7] = a7.dat;
		end
		return {oe_n, o};
	endfunction
	// digital read of port A; an undriven A5 is only read with its pull-up on
	function automatic logic [7:0] pin_rd();
		logic [15:0] c;
		logic [7:0] v;
		c = a_side();
		for (int i = 0; i < 8; i++) begin
			v[i] = !c[8+i] ? c[i] : ext_en[i] ? ext_val[i] : (i == 5);
		end
		return v & ~{3'h0, m_an[4:0]};
	endfunction
	task automatic chk_all();
		logic [15:0] c;
		logic [7:0] v;
		apsp_pkg::apsp_ovr_t [7:0] bo;
		repeat (4) @(posedge pclk); // three-edge input path plus registered outputs
		c = a_side();
		v = pin_rd();
		bo = '0;
		bo[0] = pick(1'b0, per[6], m_s0[0], per[6]);
		bo[2] = pick(!m_s1[0], per[0], !m_s0[6], per[1]);
		bo[3] = pick(1'b0, per[6], !m_s0[0], per[6]);
		bo[5] = pick(1'b0, per[0], m_s1[0], per[0]);
		bo[6] = pick(!m_s0[1], per[5], !m_s0[3], per[3]);
		bo[7] = pick(!m_s0[2], per[4], !m_s0[4], per[2]);
		`CHK(pb_ovr, bo)
		`CHK(pa_oe_n, c[15:8])
		`CHK(pa_out & ~c[15:8], c[7:0] & ~c[15:8])
		`CHK(pa5_pullup, m_wpu[5] & ~m_opt[7])
		`CHK(rx_o, m_s0[7] ? pb_pin_i[2] : pb_pin_i[1])
		`CHK(ss_o, m_s0[5] ? v[5] : pb_pin_i[5])
		`CHK(cc1_o, m_s0[0] ? pb_pin_i[0] : pb_pin_i[3])
		`CHK(cc2_o, m_s0[3] ? v[7] : pb_pin_i[6])
		rd(`APSP_OFS_PORT, {24'h0, v});
	endtask
	task automatic summarize();
		$display("miscompares=%0d check_count=%0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		static logic [7:0] tofs [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
		static logic [7:0] tval [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h1f, 8'h20, 8'h80};
		{psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
		ce_i = 1'b1;
		{ext_en, ext_val, pb_pin_i} = {8'hff, 16'h0};
		foreach (per[k]) per[k] = '0;
		{m_s0, m_s1, m_lat, m_dir, m_an, m_wpu, m_opt} = {24'h0, 8'hff, 8'h1f, 8'h20, 8'h80};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rs = $urandom(39);
		// reset image of every register
		for (int k = 0; k < 7; k++) begin
			rd(tofs[k], {24'h0, tval[k]});
		end
		chk_all();
		// random traffic over every offset plus one unmapped; steering written last
		for (int it = 0; it < 40; it++) begin
			foreach (per[k]) per[k] <= 3'($urandom);
			pb_pin_i <= 8'($urandom);
			ext_val <= 8'($urandom);
			for (int k = 10; k >= 0; k--) begin
				wr(8'(k * 4), 8'($urandom), 4'($urandom));
			end
			rd(`APSP_OFS_DIR, {24'h0, m_dir});
			rd(`APSP_OFS_LAT, {24'h0, m_lat});
			chk_all();
		end
		// pull-up alone holds A5; a direction write cannot make A5 an output
		ext_en <= 8'hdf;
		wr(`APSP_OFS_OPT, 8'h00, 4'h1);
		wr(`APSP_OFS_WPU, 8'h20, 4'h1);
		wr(`APSP_OFS_DIR, m_an, 4'h1);
		chk_all();
		ext_en <= 8'hff;
		wr(`APSP_OFS_OPT, 8'h80, 4'h1);
		chk_all();
		// clock enable low: new pin levels must not reach the receive input
		ce_i <= 1'b0;
		ext_val <= ~ext_val;
		pb_pin_i <= ~pb_pin_i;
		repeat (6) @(posedge pclk);
		`CHK(rx_o, m_s0[7] ? ~pb_pin_i[2] : ~pb_pin_i[1])
		ce_i <= 1'b1;
		chk_all();
		summarize();
	end
endmodule
